// ---- common/rucc_pkg.sv ----
// constants and types for the remote update configuration control block
// assumes a 32-bit AXI4-Lite register bus with byte addresses
package rucc_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_NEXT = 8'h04;
   localparam logic [7:0] OFS_WDT = 8'h08;
   localparam logic [7:0] OFS_KICK = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_MASK = 8'h14;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int unsigned CTRL_GO_BIT = 0;
   localparam int unsigned NEXT_WDEN_BIT = 3;
   localparam int unsigned ST_LOADERR_BIT = 0;
   localparam int unsigned ST_WDOG_BIT = 1;
   localparam int unsigned ST_EXTREQ_BIT = 2;
   localparam int unsigned ST_FACTORY_BIT = 8;
   localparam int unsigned ST_USER_BIT = 9;
   localparam int unsigned ST_REMOTE_BIT = 10;
   localparam int unsigned ST_PASYNC_BIT = 11;
   localparam int unsigned ST_PAGE_LSB = 12;
   localparam int unsigned NUM_EVENTS = 3;

   // ------------------------------------------------------------
   // pages, widths and reset values
   // ------------------------------------------------------------
   localparam int unsigned PAGE_W = 3;
   localparam logic [2:0] FACTORY_PAGE = 3'h0;
   localparam int unsigned WD_W = 24;
   localparam logic [23:0] WDT_RST = 24'hff_ffff;
   localparam logic [3:0] NEXT_RST = 4'h1;
   localparam logic [2:0] MASK_RST = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOAD = 2'b01,
      ST_USER = 2'b10
   } rucc_state_e;

endpackage

// ---- logic/rucc_watchdog.sv ----
// user watchdog counter for application images
// assumes kick and run are synchronous to aclk
`timescale 1ns/1ps
`default_nettype none
module rucc_watchdog #(
   parameter int unsigned CNT_W = 24
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic run,
   input wire logic kick,
   input wire logic [CNT_W-1:0] limit,
   output logic expired
);

   logic [CNT_W-1:0] cnt_q;

   // counts while running; a kick or a stop starts it over
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= '0;
         expired <= 1'b0;
      end else begin
         expired <= 1'b0;
         if (!run || kick) begin
            cnt_q <= '0;
         end else if (cnt_q == limit) begin
            expired <= 1'b1;
            cnt_q <= '0;
         end else begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

// ---- logic/rucc_top.sv ----
// remote update configuration control: image sequencing, watchdog,
// status and AXI4-Lite registers
// assumes a paged configuration memory that answers load_start with
// a one-cycle load_done or load_error pulse
//
// Contract
// - remote mode power-up loads the factory page 000 first
// - a failed application load falls back to the factory image in remote mode; in local mode the local page is loaded again
// - watchdog timeout is recorded in status, then factory image loads
// - watchdog is held disabled while the factory image is active
// - application load error cause goes to status, then factory image loads in remote mode, or the local page reloads in local mode
// - a clean application load enters user mode
// - next register selects any of seven application pages
// - local mode loads the single application directly at power-up
// - parallel async load strap is only sampled and reported in status; no load type is selected
// - chain-enable out of one device drives chain-enable in of next
`timescale 1ns/1ps
`default_nettype none
module rucc_top
   import rucc_pkg::*;
#(
   parameter logic [2:0] LOCAL_PAGE = 3'h1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic remote_mode,
   input wire logic parallel_async_load,
   input wire logic reconfigure_request_n,
   input wire logic chain_enable_in,
   output logic chain_enable_out,
   output logic [PAGE_W-1:0] cfg_page,
   output logic cfg_load_start,
   input wire logic cfg_load_done,
   input wire logic cfg_load_error,
   output logic user_mode,
   output logic factory_active,
   output logic irq
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   rucc_state_e state_q;
   logic remote_q;
   logic pasync_q;
   logic wd_arm_q;
   logic [WD_W-1:0] wd_limit_q;
   logic [WD_W-1:0] wdt_q;
   logic [PAGE_W-1:0] next_page_q;
   logic next_wden_q;
   logic [NUM_EVENTS-1:0] status_q;
   logic [NUM_EVENTS-1:0] mask_q;
   logic [NUM_EVENTS-1:0] event_set;
   logic [NUM_EVENTS-1:0] event_clr;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wr_fire;
   logic [31:0] wr_bits;
   logic go;
   logic kick;
   logic wd_expired;
   logic wd_run;
   logic load_fail;
   logic [31:0] rd_word;
   logic rd_hit;

   // ------------------------------------------------------------
   // axi4-lite write channel
   // ------------------------------------------------------------
   // address and data are each taken once; the write happens when
   // both are held and no response is pending
   assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         awaddr_q <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         awaddr_q <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b1;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         case (awaddr_q)
            OFS_CTRL, OFS_NEXT, OFS_WDT, OFS_KICK, OFS_STATUS, OFS_MASK: begin
               s_axi_bresp <= RESP_OKAY;
            end
            default: begin
               s_axi_bresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // bytes not enabled read as zero so fields only see written lanes
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_lane
         assign wr_bits[gi*8 +: 8] = wstrb_q[gi] ? wdata_q[gi*8 +: 8] : 8'h00;
      end
   endgenerate

   assign go = wr_fire && (awaddr_q == OFS_CTRL) && wr_bits[CTRL_GO_BIT];
   assign kick = wr_fire && (awaddr_q == OFS_KICK) && (wstrb_q != 4'h0);

   // ------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         next_page_q <= NEXT_RST[PAGE_W-1:0];
         next_wden_q <= NEXT_RST[NEXT_WDEN_BIT];
      end else if (wr_fire && awaddr_q == OFS_NEXT && wstrb_q[0]) begin
         next_page_q <= wdata_q[PAGE_W-1:0];
         next_wden_q <= wdata_q[NEXT_WDEN_BIT];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wdt_q <= WDT_RST;
      end else if (wr_fire && awaddr_q == OFS_WDT) begin
         for (int i = 0; i < 3; i++) begin
            if (wstrb_q[i]) begin
               wdt_q[i*8 +: 8] <= wdata_q[i*8 +: 8];
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_q <= MASK_RST;
      end else if (wr_fire && awaddr_q == OFS_MASK && wstrb_q[0]) begin
         mask_q <= wdata_q[NUM_EVENTS-1:0];
      end
   end

   // ------------------------------------------------------------
   // status and interrupt
   // ------------------------------------------------------------
   assign load_fail = (state_q == ST_LOAD) && cfg_load_error && !cfg_load_done;
   assign event_set[ST_LOADERR_BIT] = load_fail && !factory_active;
   assign event_set[ST_WDOG_BIT] = wd_expired;
   assign event_set[ST_EXTREQ_BIT] = !reconfigure_request_n;
   assign event_clr = (wr_fire && awaddr_q == OFS_STATUS) ?
                      wr_bits[NUM_EVENTS-1:0] : '0;

   // a new event wins over a write-one-to-clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_q <= '0;
      end else begin
         status_q <= (status_q & ~event_clr) | event_set;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_q & mask_q);
      end
   end

   // ------------------------------------------------------------
   // axi4-lite read channel
   // ------------------------------------------------------------
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit = 1'b1;
      case (s_axi_araddr)
         OFS_CTRL: begin
            rd_word = 32'h0000_0000;
         end
         OFS_NEXT: begin
            rd_word[PAGE_W-1:0] = next_page_q;
            rd_word[NEXT_WDEN_BIT] = next_wden_q;
         end
         OFS_WDT: begin
            rd_word[WD_W-1:0] = wdt_q;
         end
         OFS_KICK: begin
            rd_word = 32'h0000_0000;
         end
         OFS_STATUS: begin
            rd_word[NUM_EVENTS-1:0] = status_q;
            rd_word[ST_FACTORY_BIT] = factory_active;
            rd_word[ST_USER_BIT] = user_mode;
            rd_word[ST_REMOTE_BIT] = remote_q;
            rd_word[ST_PASYNC_BIT] = pasync_q;
            rd_word[ST_PAGE_LSB +: PAGE_W] = cfg_page;
         end
         OFS_MASK: begin
            rd_word[NUM_EVENTS-1:0] = mask_q;
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // user watchdog
   // ------------------------------------------------------------
   // never runs for the factory image or outside user mode
   assign wd_run = user_mode && wd_arm_q && !factory_active;

   rucc_watchdog #(
      .CNT_W(WD_W)
   ) u_wdog (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(wd_run),
      .kick(kick),
      .limit(wd_limit_q),
      .expired(wd_expired)
   );

   // ------------------------------------------------------------
   // image load sequencer
   // ------------------------------------------------------------
   // straps are sampled every time the sequence restarts, so a
   // reconfiguration request behaves like a fresh power-up
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         remote_q <= 1'b1;
         pasync_q <= 1'b0;
      end else if (state_q == ST_IDLE) begin
         remote_q <= remote_mode;
         pasync_q <= parallel_async_load;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= ST_IDLE;
         cfg_page <= FACTORY_PAGE;
         cfg_load_start <= 1'b0;
         factory_active <= 1'b1;
         user_mode <= 1'b0;
         chain_enable_out <= 1'b0;
         wd_arm_q <= 1'b0;
         wd_limit_q <= WDT_RST;
      end else begin
         cfg_load_start <= 1'b0;
         if (!reconfigure_request_n) begin
            state_q <= ST_IDLE;
            user_mode <= 1'b0;
            chain_enable_out <= 1'b0;
            wd_arm_q <= 1'b0;
         end else begin
            case (state_q)
               ST_IDLE: begin
                  // loading waits for the previous device in the chain
                  if (chain_enable_in) begin
                     state_q <= ST_LOAD;
                     cfg_load_start <= 1'b1;
                     wd_arm_q <= 1'b0;
                     if (remote_mode) begin
                        cfg_page <= FACTORY_PAGE;
                        factory_active <= 1'b1;
                     end else begin
                        cfg_page <= LOCAL_PAGE;
                        factory_active <= 1'b0;
                     end
                  end
               end
               ST_LOAD: begin
                  if (cfg_load_done) begin
                     state_q <= ST_USER;
                     user_mode <= 1'b1;
                     chain_enable_out <= 1'b1;
                  end else if (load_fail) begin
                     cfg_load_start <= 1'b1;
                     if (remote_q) begin
                        cfg_page <= FACTORY_PAGE;
                        factory_active <= 1'b1;
                        wd_arm_q <= 1'b0;
                     end
                  end
               end
               ST_USER: begin
                  if (wd_expired || go) begin
                     state_q <= ST_LOAD;
                     user_mode <= 1'b0;
                     chain_enable_out <= 1'b0;
                     cfg_load_start <= 1'b1;
                     if (!remote_q) begin
                        cfg_page <= LOCAL_PAGE;
                        wd_arm_q <= 1'b0;
                     end else if (factory_active && !wd_expired) begin
                        // factory picked the page and watchdog setup
                        cfg_page <= next_page_q;
                        factory_active <= (next_page_q == FACTORY_PAGE);
                        wd_arm_q <= next_wden_q && (next_page_q != FACTORY_PAGE);
                        wd_limit_q <= wdt_q;
                     end else begin
                        cfg_page <= FACTORY_PAGE;
                        factory_active <= 1'b1;
                        wd_arm_q <= 1'b0;
                     end
                  end
               end
               default: begin
                  state_q <= ST_IDLE;
               end
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// ---- testbench/rucc_checker.sv ----
// port assertions for the remote update configuration control block
// assumes a bind onto rucc_top, one clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module rucc_checker
   import rucc_pkg::*;
#(
   parameter logic [2:0] LOCAL_PAGE = 3'h1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic remote_mode,
   input wire logic reconfigure_request_n,
   input wire logic chain_enable_out,
   input wire logic [PAGE_W-1:0] cfg_page,
   input wire logic cfg_load_start,
   input wire logic cfg_load_done,
   input wire logic cfg_load_error,
   input wire logic user_mode,
   input wire logic factory_active
);
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // answers outside a load are ignored by the design, so only judge in-flight ones
   logic pend_q;
   logic wtake_q;
   always_ff @(posedge aclk) begin
      if (!aresetn || !reconfigure_request_n) begin
         pend_q <= 1'b0;
      end else if (cfg_load_start) begin
         pend_q <= 1'b1;
      end else if (cfg_load_done || cfg_load_error) begin
         pend_q <= 1'b0;
      end
   end
   always_ff @(posedge aclk) wtake_q <= aresetn && s_axi_wvalid && s_axi_wready;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   AST_FACTORY_PAGE: assert property (
      factory_active && user_mode |-> cfg_page == FACTORY_PAGE) else $error("factory not on page 0");
   AST_LOAD_OK: assert property (
      pend_q && cfg_load_done && reconfigure_request_n |=> user_mode) else $error("no user mode");
   AST_ERR_FALLBACK: assert property (
      pend_q && cfg_load_error && !cfg_load_done && remote_mode && reconfigure_request_n
      |-> ##[1:3] cfg_load_start && cfg_page == FACTORY_PAGE) else $error("no factory fallback");
   AST_CHAIN_OUT: assert property (
      chain_enable_out == user_mode) else $error("chain enable out differs from user mode");
   AST_FACTORY_NO_WDOG: assert property (
      factory_active && user_mode && reconfigure_request_n && !s_axi_wvalid && !wtake_q
      |=> user_mode) else $error("factory image left user mode");
   AST_RECONFIG_IDLE: assert property (
      !reconfigure_request_n |=> !user_mode && !cfg_load_start) else $error("not held idle");
   AST_LOCAL_PAGE: assert property (
      cfg_load_start && !remote_mode |-> cfg_page == LOCAL_PAGE) else $error("wrong local page");
   AST_START_PULSE: assert property (
      cfg_load_start |=> !cfg_load_start) else $error("load start longer than one cycle");
endmodule
bind rucc_top rucc_checker #(.LOCAL_PAGE(LOCAL_PAGE)) u_rucc_checker (
   .aclk(aclk), .aresetn(aresetn), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .remote_mode(remote_mode), .reconfigure_request_n(reconfigure_request_n),
   .chain_enable_out(chain_enable_out), .cfg_page(cfg_page), .cfg_load_start(cfg_load_start),
   .cfg_load_done(cfg_load_done), .cfg_load_error(cfg_load_error), .user_mode(user_mode),
   .factory_active(factory_active)
);
`default_nettype wire

// ---- testbench/rucc_mem_model.sv ----
// paged configuration memory answering each load request after lat+1 cycles
// assumes start pulses are one cycle and never overlap a load in flight
`timescale 1ns/1ps
`default_nettype none
module rucc_mem_model
   import rucc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [PAGE_W-1:0] cfg_page,
   input wire logic cfg_load_start,
   input wire logic [7:0] bad_pages,
   input wire logic [3:0] lat,
   output logic cfg_load_done,
   output logic cfg_load_error
);
   int cnt;
   logic [PAGE_W-1:0] page_q;
   always @(posedge aclk) begin
      cfg_load_done <= 1'b0;
      cfg_load_error <= 1'b0;
      if (!aresetn || cfg_load_start) begin
         cnt <= aresetn ? int'(lat) + 1 : 0;
         page_q <= cfg_page;
      end else if (cnt == 1) begin
         cnt <= 0;
         // the factory page is never rewritten, so it always loads
         if (bad_pages[page_q] && page_q != FACTORY_PAGE) begin
            cfg_load_error <= 1'b1;
         end else begin
            cfg_load_done <= 1'b1;
         end
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// self-checking bench for rucc_top with a paged memory model
// assumes the package register map and a 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import rucc_pkg::*;
   localparam logic [2:0] LPAGE = 3'h5;
   logic aclk;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, bad_pages = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, chain_enable_in = 1'b1;
   logic remote_mode = 1'b1, parallel_async_load = 1'b0, reconfigure_request_n = 1'b1;
   logic [3:0] lat = 4'h2, s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic chain_enable_out, cfg_load_start, cfg_load_done, cfg_load_error;
   logic user_mode, factory_active, irq;
   logic [2:0] cfg_page;
   int miscompares = 0, tests_run = 0, seed;
   logic [2:0] starts[$];
   rucc_top #(.LOCAL_PAGE(LPAGE)) uut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .remote_mode(remote_mode),
      .parallel_async_load(parallel_async_load), .reconfigure_request_n(reconfigure_request_n),
      .chain_enable_in(chain_enable_in), .chain_enable_out(chain_enable_out),
      .cfg_page(cfg_page), .cfg_load_start(cfg_load_start), .cfg_load_done(cfg_load_done),
      .cfg_load_error(cfg_load_error), .user_mode(user_mode), .factory_active(factory_active),
      .irq(irq)
   );
   rucc_mem_model u_mem (
      .aclk(aclk), .aresetn(aresetn), .cfg_page(cfg_page), .cfg_load_start(cfg_load_start),
      .bad_pages(bad_pages), .lat(lat), .cfg_load_done(cfg_load_done),
      .cfg_load_error(cfg_load_error)
   );
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // every load request is queued so that none is missed while a bus cycle runs
   always @(posedge aclk) if (cfg_load_start === 1'b1) starts.push_back(cfg_page);
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t word got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t bit got %b exp %b", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] st_word(input int stk, input int pg, input int usr,
                                           input int fac);
      return (32'(pg) << ST_PAGE_LSB) | (32'(parallel_async_load) << ST_PASYNC_BIT)
         | (32'(remote_mode) << ST_REMOTE_BIT) | (32'(usr) << ST_USER_BIT)
         | (32'(fac) << ST_FACTORY_BIT) | 32'(stk);
   endfunction
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && s_axi_awready === 1'b1) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready === 1'b1) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk32({30'h0, s_axi_bresp}, {30'h0, er});
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk32(s_axi_rdata, ed);
      chk32({30'h0, s_axi_rresp}, {30'h0, er});
   endtask
   task automatic wait_start(input logic [2:0] ep);
      while (starts.size() == 0) @(posedge aclk);
      chk32(32'(starts.pop_front()), 32'(ep));
   endtask
   task automatic wait_user();
      do @(posedge aclk); while (user_mode !== 1'b1);
   endtask
   task automatic go(input int nxt);
      lat <= 4'($random(seed));
      axi_wr(OFS_NEXT, 32'(nxt), RESP_OKAY);
      axi_wr(OFS_CTRL, 32'h1, RESP_OKAY);
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      #400000;
      miscompares++;
      print_verdict();
   end
   initial begin
      seed = 32'h6fcebfa3;
      repeat (3) @(posedge aclk);
      chk1(user_mode, 1'b0);
      chk1(factory_active, 1'b1);
      aresetn <= 1'b1;
      wait_start(FACTORY_PAGE);
      wait_user();
      axi_rd(OFS_STATUS, st_word(0, 0, 1, 1), RESP_OKAY);
      axi_rd(OFS_NEXT, 32'(NEXT_RST), RESP_OKAY);
      s_axi_wstrb <= 4'he;
      axi_wr(OFS_NEXT, 32'h7, RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      axi_rd(OFS_NEXT, 32'(NEXT_RST), RESP_OKAY);
      axi_rd(OFS_WDT, 32'(WDT_RST), RESP_OKAY);
      axi_rd(OFS_MASK, 32'(MASK_RST), RESP_OKAY);
      axi_wr(8'h40, 32'h1, RESP_SLVERR);
      axi_rd(8'h40, 32'h0, RESP_SLVERR);
      $display("test boot done");
      for (int p = 1; p < 8; p++) begin
         go(p);
         wait_start(3'(p));
         wait_user();
         chk1(factory_active, 1'b0);
         axi_rd(OFS_STATUS, st_word(0, p, 1, 0), RESP_OKAY);
         axi_wr(OFS_CTRL, 32'h1, RESP_OKAY);
         wait_start(FACTORY_PAGE);
         wait_user();
      end
      $display("test pages done");
      axi_wr(OFS_WDT, 32'd20, RESP_OKAY);
      go(32'h0000000b);
      wait_start(3'h3);
      wait_user();
      repeat (6) begin
         repeat (10) @(posedge aclk);
         axi_wr(OFS_KICK, 32'($random(seed)), RESP_OKAY);
      end
      repeat (15) @(posedge aclk);
      chk1(user_mode, 1'b1);
      wait_start(FACTORY_PAGE);
      wait_user();
      axi_rd(OFS_STATUS, st_word(2, 0, 1, 1), RESP_OKAY);
      axi_wr(OFS_STATUS, 32'h2, RESP_OKAY);
      repeat (40) @(posedge aclk);
      chk1(user_mode, 1'b1);
      $display("test watchdog done");
      bad_pages <= 8'h20;
      go(5);
      wait_start(3'h5);
      wait_start(FACTORY_PAGE);
      wait_user();
      bad_pages <= 8'h00;
      axi_rd(OFS_STATUS, st_word(1, 0, 1, 1), RESP_OKAY);
      axi_wr(OFS_MASK, 32'h1, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk1(irq, 1'b1);
      axi_wr(OFS_MASK, 32'h2, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk1(irq, 1'b0);
      axi_wr(OFS_MASK, 32'h1, RESP_OKAY);
      axi_wr(OFS_STATUS, 32'h1, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk1(irq, 1'b0);
      $display("test load error done");
      reconfigure_request_n <= 1'b0;
      repeat (5) @(posedge aclk);
      chk1(user_mode, 1'b0);
      chain_enable_in <= 1'b0;
      reconfigure_request_n <= 1'b1;
      repeat (5) @(posedge aclk);
      chk32(32'(starts.size()), 32'h0);
      chain_enable_in <= 1'b1;
      wait_start(FACTORY_PAGE);
      wait_user();
      axi_rd(OFS_STATUS, st_word(4, 0, 1, 1), RESP_OKAY);
      $display("test reconfigure done");
      reconfigure_request_n <= 1'b0;
      remote_mode <= 1'b0;
      parallel_async_load <= 1'b1;
      repeat (3) @(posedge aclk);
      reconfigure_request_n <= 1'b1;
      wait_start(LPAGE);
      wait_user();
      chk1(factory_active, 1'b0);
      axi_rd(OFS_STATUS, st_word(4, LPAGE, 1, 0), RESP_OKAY);
      $display("test local mode done");
      print_verdict();
   end
endmodule
`default_nettype wire
